// File: shared/sgc_pkg.sv
package sgc_pkg;
	localparam int          ADDR_W          = 32;
	localparam int          DATA_W          = 32;
	localparam int          REG_AW          = 8;
	// Block gate geometry
	localparam int          BLK_BYTES       = 256;
	localparam int          BLK_OFF_W       = $clog2(BLK_BYTES);
	localparam int          NUM_BLOCKS      = 64;
	localparam int          NUM_PERIPH      = 16;
	localparam int          SRAM_BYTES      = NUM_BLOCKS * BLK_BYTES;
	localparam int          SRAM_AW         = $clog2(SRAM_BYTES);
	// Refused read value and forbidden encoding
	localparam logic [15:0] SECURE_GATEWAY_OPCODE = 16'hE97F;
	localparam logic [31:0] REFUSE_RDATA    = 32'h0000_0000;
	// Register byte offsets
	localparam logic [7:0]  OFF_CTRL        = 8'h00;
	localparam logic [7:0]  OFF_WMARK       = 8'h04;
	localparam logic [7:0]  OFF_PNS         = 8'h08;
	localparam logic [7:0]  OFF_PPRIV       = 8'h0C;
	localparam logic [7:0]  OFF_EVADDR      = 8'h10;
	localparam logic [7:0]  OFF_EVINFO      = 8'h14;
	localparam logic [7:0]  OFF_BLK0        = 8'h20;
	// Control field positions
	localparam int          CTRL_ABORT_BIT  = 0;
	localparam int          CTRL_SWR_BIT    = 1;
	localparam int          CTRL_WMEN_BIT   = 2;
	localparam int          CTRL_PSREF_BIT  = 3;
	// Reset values: everything Secure
	localparam logic [3:0]  CTRL_RST        = 4'h0;
	localparam logic [31:0] WMARK_RST       = 32'h0000_0000;

	typedef struct packed {
		logic              valid;
		logic              write;
		logic              nonsec;
		logic              priv;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} sgc_req_type;

	typedef struct packed {
		logic              valid;
		logic              error;
		logic [DATA_W-1:0] rdata;
	} sgc_rsp_type;

	typedef struct packed {
		logic              pulse;
		logic              nonsec;
		logic              write;
		logic [1:0]        src;
		logic [ADDR_W-1:0] addr;
	} sgc_evt_type;
endpackage : sgc_pkg

// File: hdl/sgc_gate.sv
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module sgc_gate
	import sgc_pkg::*;
#(
	parameter int NBLK = NUM_BLOCKS,
	parameter int NPER = NUM_PERIPH,
	parameter int BLKB = BLK_BYTES
) (
	input  wire logic              ref_clk_i,
	input  wire logic              rst_b_i,
	input  wire logic [REG_AW-1:0] reg_addr_i,
	input  wire logic [DATA_W-1:0] reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	input  wire logic              reg_nonsec_i,
	output      logic [DATA_W-1:0] reg_rdata_o,
	input  wire sgc_req_type       blk_req_i,
	output      sgc_req_type       blk_req_o,
	output      sgc_rsp_type       blk_rsp_o,
	input  wire sgc_rsp_type       blk_rsp_i,
	input  wire sgc_req_type       wm_req_i,
	output      sgc_req_type       wm_req_o,
	output      sgc_rsp_type       wm_rsp_o,
	input  wire sgc_rsp_type       wm_rsp_i,
	input  wire sgc_req_type       per_req_i,
	input  wire logic [NPER-1:0]   per_sel_i,
	output      sgc_req_type       per_req_o,
	output      logic [NPER-1:0]   per_sel_o,
	output      sgc_rsp_type       per_rsp_o,
	input  wire sgc_rsp_type       per_rsp_i,
	output      sgc_evt_type       evt_o
);
	localparam int BOFF = $clog2(BLKB);
	localparam int BIW  = $clog2(NBLK);
	localparam int NBW  = (NBLK + 31) / 32;

	logic [3:0]        ctrl_q, ctrl_d;
	logic [31:0]       wmark_q, wmark_d;
	logic [NPER-1:0]   pns_q, pns_d, ppriv_q, ppriv_d;
	logic [NBLK-1:0]   blkns_q, blkns_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic [31:0]       evaddr_q, evaddr_d;
	logic [3:0]        evinfo_q, evinfo_d;
	sgc_evt_type       evt_q, evt_d;
	sgc_rsp_type       brsp_q, brsp_d, wrsp_q, wrsp_d, prsp_q, prsp_d;
	logic              blk_ref, wm_ref, per_ref, per_ns_ok, per_priv_ok;
	logic [BIW-1:0]    bidx;

	// Common refusal decision for a region marked Non-secure or not
	function automatic logic refuse(input sgc_req_type r, input logic region_ns,
		input logic swr);
		if (r.nonsec)
			refuse = !region_ns;
		else if (region_ns)
			refuse = !r.write || swr;
		else
			refuse = 1'b0;
	endfunction : refuse

	// Answer for a refused access
	function automatic sgc_rsp_type refuse_rsp(input logic valid, input logic abort);
		refuse_rsp.valid = valid;
		refuse_rsp.error = valid && abort;
		refuse_rsp.rdata = REFUSE_RDATA;
	endfunction : refuse_rsp

	// Block control word select
	function automatic logic blk_word_hit(input logic [REG_AW-1:0] a, input int w);
		blk_word_hit = (a == OFF_BLK0 + 8'(4 * w));
	endfunction : blk_word_hit

	assign bidx = blk_req_i.addr[BOFF+BIW-1:BOFF];

	always_comb begin
		blk_ref = blk_req_i.valid &&
			refuse(blk_req_i, blkns_q[bidx], ctrl_q[CTRL_SWR_BIT]);
		wm_ref  = wm_req_i.valid && refuse(wm_req_i,
			ctrl_q[CTRL_WMEN_BIT] && (wm_req_i.addr < wmark_q),
			ctrl_q[CTRL_SWR_BIT]);
		per_ns_ok   = |(per_sel_i & pns_q);
		per_priv_ok = per_req_i.priv || !(|(per_sel_i & ppriv_q));
		per_ref = per_req_i.valid && ((per_req_i.nonsec && !per_ns_ok) ||
			(!per_req_i.nonsec && per_ns_ok && ctrl_q[CTRL_PSREF_BIT]) ||
			!per_priv_ok);
	end

	// Forwarding; refused requests never reach the target
	always_comb begin
		blk_req_o       = blk_req_i;
		blk_req_o.valid = blk_req_i.valid && !blk_ref;
		wm_req_o        = wm_req_i;
		wm_req_o.valid  = wm_req_i.valid && !wm_ref;
		per_req_o       = per_req_i;
		per_req_o.valid = per_req_i.valid && !per_ref;
		per_sel_o       = per_ref ? '0 : per_sel_i;
		blk_rsp_o       = brsp_q.valid ? brsp_q : blk_rsp_i;
		wm_rsp_o        = wrsp_q.valid ? wrsp_q : wm_rsp_i;
		per_rsp_o       = prsp_q.valid ? prsp_q : per_rsp_i;
		evt_o           = evt_q;
	end

	// Local refusal answers one cycle after the request
	always_comb begin
		brsp_d = refuse_rsp(blk_ref, ctrl_q[CTRL_ABORT_BIT]);
		wrsp_d = refuse_rsp(wm_ref, ctrl_q[CTRL_ABORT_BIT]);
		prsp_d = refuse_rsp(per_ref, ctrl_q[CTRL_ABORT_BIT]);
	end

	// Event pulse, block gate has priority
	always_comb begin
		evt_d    = '0;
		evaddr_d = evaddr_q;
		evinfo_d = evinfo_q;
		if (blk_ref) begin
			evt_d = '{1'b1, blk_req_i.nonsec, blk_req_i.write, 2'h0, blk_req_i.addr};
		end else if (wm_ref) begin
			evt_d = '{1'b1, wm_req_i.nonsec, wm_req_i.write, 2'h1, wm_req_i.addr};
		end else if (per_ref) begin
			evt_d = '{1'b1, per_req_i.nonsec, per_req_i.write, 2'h2, per_req_i.addr};
		end
		if (evt_d.pulse) begin
			evaddr_d = evt_d.addr;
			evinfo_d = {evt_d.src, evt_d.write, evt_d.nonsec};
		end
	end

	// Register writes and reads
	always_comb begin
		ctrl_d  = ctrl_q;
		wmark_d = wmark_q;
		pns_d   = pns_q;
		ppriv_d = ppriv_q;
		blkns_d = blkns_q;
		rdata_d = '0;
		if (reg_wr_i && !reg_nonsec_i) begin
			case (reg_addr_i)
				OFF_CTRL:  ctrl_d  = reg_wdata_i[3:0];
				OFF_WMARK: wmark_d = reg_wdata_i;
				OFF_PNS:   pns_d   = reg_wdata_i[NPER-1:0];
				OFF_PPRIV: ppriv_d = reg_wdata_i[NPER-1:0];
				default: begin
					for (int w = 0; w < NBW; w++) begin
						if (blk_word_hit(reg_addr_i, w)) begin
							for (int b = 0; b < 32; b++) begin
								if (w * 32 + b < NBLK)
									blkns_d[w * 32 + b] = reg_wdata_i[b];
							end
						end
					end
				end
			endcase
		end
		if (reg_rd_i) begin
			case (reg_addr_i)
				OFF_CTRL:   rdata_d = {28'h0, ctrl_q};
				OFF_WMARK:  rdata_d = wmark_q;
				OFF_PNS:    rdata_d = 32'(pns_q);
				OFF_PPRIV:  rdata_d = 32'(ppriv_q);
				OFF_EVADDR: rdata_d = evaddr_q;
				OFF_EVINFO: rdata_d = {28'h0, evinfo_q};
				default: begin
					for (int w = 0; w < NBW; w++) begin
						if (blk_word_hit(reg_addr_i, w)) begin
							for (int b = 0; b < 32; b++) begin
								if (w * 32 + b < NBLK)
									rdata_d[b] = blkns_q[w * 32 + b];
							end
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_q  <= CTRL_RST;
			wmark_q <= WMARK_RST;
			pns_q   <= '0;
			ppriv_q <= '0;
			blkns_q <= '0;
			rdata_q <= '0;
		end else begin
			ctrl_q  <= ctrl_d;
			wmark_q <= wmark_d;
			pns_q   <= pns_d;
			ppriv_q <= ppriv_d;
			blkns_q <= blkns_d;
			rdata_q <= rdata_d;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			evaddr_q <= '0;
			evinfo_q <= '0;
			evt_q    <= '0;
		end else begin
			evaddr_q <= evaddr_d;
			evinfo_q <= evinfo_d;
			evt_q    <= evt_d;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			brsp_q <= '0;
			wrsp_q <= '0;
			prsp_q <= '0;
		end else begin
			brsp_q <= brsp_d;
			wrsp_q <= wrsp_d;
			prsp_q <= prsp_d;
		end
	end

	assign reg_rdata_o = rdata_q;

	// Checks
	property p_ns_to_sec_blk;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		(blk_req_i.valid && blk_req_i.nonsec && !blkns_q[bidx]) |-> !blk_req_o.valid;
	endproperty
	a_ns_to_sec_blk: assert property (p_ns_to_sec_blk) else $error("ns reached secure block");

	property p_sec_rd_ns_blk;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		(blk_req_i.valid && !blk_req_i.nonsec && !blk_req_i.write && blkns_q[bidx])
		|-> ##1 (blk_rsp_o.valid && blk_rsp_o.rdata == REFUSE_RDATA);
	endproperty
	a_sec_rd_ns_blk: assert property (p_sec_rd_ns_blk) else $error("secure read not refused");

	property p_swr;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		(blk_req_i.valid && !blk_req_i.nonsec && blk_req_i.write && blkns_q[bidx])
		|-> (blk_req_o.valid == !ctrl_q[CTRL_SWR_BIT]);
	endproperty
	a_swr: assert property (p_swr) else $error("secure write option wrong");

	property p_abort;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		blk_ref |-> ##1 (blk_rsp_o.error == $past(ctrl_q[CTRL_ABORT_BIT]));
	endproperty
	a_abort: assert property (p_abort) else $error("refusal response kind wrong");

	property p_evt;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		(blk_ref || wm_ref || per_ref) |-> ##1
			(evt_o.pulse ##1 (!evt_o.pulse || $past(blk_ref || wm_ref || per_ref)));
	endproperty
	a_evt: assert property (p_evt) else $error("missing event pulse");

	property p_no_gw;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		brsp_q.valid |-> (blk_rsp_o.rdata[15:0] != SECURE_GATEWAY_OPCODE);
	endproperty
	a_no_gw: assert property (p_no_gw) else $error("gateway opcode returned");

	property p_wm;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		(wm_req_i.valid && wm_req_i.nonsec && (!ctrl_q[CTRL_WMEN_BIT] || wm_req_i.addr >= wmark_q))
		|-> !wm_req_o.valid;
	endproperty
	a_wm: assert property (p_wm) else $error("ns reached secure sram");

	property p_per;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		(per_req_i.valid && per_req_i.nonsec && !(|(per_sel_i & pns_q))) |-> per_sel_o == '0;
	endproperty
	a_per: assert property (p_per) else $error("ns reached secure peripheral");

	property p_cfg;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		(reg_wr_i && reg_nonsec_i) |=> ($stable(ctrl_q) && $stable(blkns_q) && $stable(wmark_q));
	endproperty
	a_cfg: assert property (p_cfg) else $error("ns changed settings");

	property p_ns_ok_blk;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		(blk_req_i.valid && blk_req_i.nonsec && blkns_q[bidx]) |-> blk_req_o.valid;
	endproperty
	a_ns_ok_blk: assert property (p_ns_ok_blk) else $error("ns kept from ns block");

	property p_evt_blk;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		blk_ref |=> (evt_o.src == 2'h0 && evt_o.addr == $past(blk_req_i.addr) &&
			evt_o.nonsec == $past(blk_req_i.nonsec));
	endproperty
	a_evt_blk: assert property (p_evt_blk) else $error("event payload wrong");

	property p_evt_cause;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		evt_o.pulse |-> $past(blk_ref || wm_ref || per_ref);
	endproperty
	a_evt_cause: assert property (p_evt_cause) else $error("event without refusal");

	property p_wm_sec_rd;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		(wm_req_i.valid && !wm_req_i.nonsec && !wm_req_i.write && ctrl_q[CTRL_WMEN_BIT] &&
			wm_req_i.addr < wmark_q) |-> !wm_req_o.valid;
	endproperty
	a_wm_sec_rd: assert property (p_wm_sec_rd) else $error("secure read of ns sram");

	property p_wm_rsp;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		wm_ref |-> ##1 (wm_rsp_o.valid && wm_rsp_o.rdata == REFUSE_RDATA &&
			wm_rsp_o.error == $past(ctrl_q[CTRL_ABORT_BIT]));
	endproperty
	a_wm_rsp: assert property (p_wm_rsp) else $error("sram refusal answer wrong");

	property p_wm_ok;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		(wm_req_i.valid && wm_req_i.nonsec && ctrl_q[CTRL_WMEN_BIT] &&
			wm_req_i.addr < wmark_q) |-> wm_req_o.valid;
	endproperty
	a_wm_ok: assert property (p_wm_ok) else $error("ns kept from ns sram");

	property p_per_valid;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		(per_req_i.valid && per_req_i.nonsec && !(|(per_sel_i & pns_q))) |-> !per_req_o.valid;
	endproperty
	a_per_valid: assert property (p_per_valid) else $error("ns request forwarded");

	property p_per_ok;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		(per_req_i.valid && per_req_i.nonsec && per_req_i.priv &&
			(|(per_sel_i & pns_q))) |-> per_req_o.valid;
	endproperty
	a_per_ok: assert property (p_per_ok) else $error("ns kept from ns peripheral");

	property p_per_priv;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		(per_req_i.valid && !per_req_i.priv && (|(per_sel_i & ppriv_q))) |->
			(!per_req_o.valid && per_sel_o == '0);
	endproperty
	a_per_priv: assert property (p_per_priv) else $error("unprivileged access passed");

	property p_per_sec;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		(per_req_i.valid && !per_req_i.nonsec && (|(per_sel_i & pns_q)) &&
			ctrl_q[CTRL_PSREF_BIT]) |-> !per_req_o.valid;
	endproperty
	a_per_sec: assert property (p_per_sec) else $error("secure to ns peripheral passed");

	property p_per_rsp;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		per_ref |-> ##1 (per_rsp_o.valid &&
			per_rsp_o.error == $past(ctrl_q[CTRL_ABORT_BIT]));
	endproperty
	a_per_rsp: assert property (p_per_rsp) else $error("peripheral refusal answer wrong");

	property p_cfg_per;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		(reg_wr_i && reg_nonsec_i) |=> ($stable(pns_q) && $stable(ppriv_q));
	endproperty
	a_cfg_per: assert property (p_cfg_per) else $error("ns changed peripheral bits");

	c_blk_ref: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) blk_ref);
	c_wm_ref:  cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) wm_ref);
	c_per_ref: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) per_ref);
	c_pass:    cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) blk_req_o.valid);
	c_evt:     cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) evt_o.pulse);
endmodule : sgc_gate

// File: testbench/sgc_target_model.sv
`timescale 1ns/100ps
module sgc_target_model
	import sgc_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        rst_b_i,
	input  wire sgc_req_type req_i,
	output      sgc_rsp_type rsp_o
);
	sgc_rsp_type rsp_q;
	sgc_rsp_type rsp_d;
	always_comb begin
		rsp_d = '0;
		rsp_d.valid = req_i.valid;
		// Idle data flips so a stale word never passes for an answer
		rsp_d.rdata = req_i.valid ? (req_i.addr ^ 32'h5A5A_0000) : ~rsp_q.rdata;
	end
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rsp_q <= '0;
		end else begin
			rsp_q <= rsp_d;
		end
	end
	assign rsp_o = rsp_q;
endmodule : sgc_target_model

// File: testbench/sgc_gate_test.sv
`timescale 1ns/100ps
module sgc_gate_test
	import sgc_pkg::*;
;
	logic                  ref_clk_i;
	logic                  rst_b_i;
	logic [REG_AW-1:0]     ra;
	logic [DATA_W-1:0]     rwd;
	logic [DATA_W-1:0]     rrd;
	logic                  rwr;
	logic                  rrd_s;
	logic                  rns;
	sgc_req_type           breq, bfwd, wreq, wfwd, preq, pfwd;
	sgc_rsp_type           brsp, btgt, wrsp, wtgt, prsp, ptgt;
	logic [NUM_PERIPH-1:0] psel;
	logic [NUM_PERIPH-1:0] psel_fwd;
	sgc_evt_type           evt;
	int                    num_errors;
	int                    checks_done;
	int                    cycles;

	sgc_gate i_sgc_gate (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(ra),
		.reg_wdata_i(rwd), .reg_wr_i(rwr), .reg_rd_i(rrd_s), .reg_nonsec_i(rns),
		.reg_rdata_o(rrd), .blk_req_i(breq), .blk_req_o(bfwd), .blk_rsp_o(brsp),
		.blk_rsp_i(btgt), .wm_req_i(wreq), .wm_req_o(wfwd), .wm_rsp_o(wrsp),
		.wm_rsp_i(wtgt), .per_req_i(preq), .per_sel_i(psel), .per_req_o(pfwd),
		.per_sel_o(psel_fwd), .per_rsp_o(prsp), .per_rsp_i(ptgt), .evt_o(evt));
	sgc_target_model i_sgc_target_model_b (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
		.req_i(bfwd), .rsp_o(btgt));
	sgc_target_model i_sgc_target_model_w (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
		.req_i(wfwd), .rsp_o(wtgt));
	sgc_target_model i_sgc_target_model_p (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
		.req_i(pfwd), .rsp_o(ptgt));

	task automatic test_done;
		if (num_errors == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : test_done

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic check_bit(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t flag %b expected %b", $time, got, exp);
		end
	endtask : check_bit

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d, input logic ns);
		@(posedge ref_clk_i);
		ra <= a;
		rwd <= d;
		rns <= ns;
		rwr <= 1'b1;
		@(posedge ref_clk_i);
		rwr <= 1'b0;
		rns <= 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
		@(posedge ref_clk_i);
		ra <= a;
		rrd_s <= 1'b1;
		@(posedge ref_clk_i);
		rrd_s <= 1'b0;
		#1;
		check(rrd, exp);
	endtask : reg_read

	// One gate transfer; rf says refused, e the expected error bit
	task automatic access(input int s, input logic w, n, p, input logic [31:0] a,
			input logic [15:0] sel, input logic rf, e);
		sgc_req_type r;
		sgc_req_type f;
		sgc_rsp_type q;
		r = '{valid: 1'b1, write: w, nonsec: n, priv: p, addr: a, wdata: 32'hC3C3_0F0F};
		@(posedge ref_clk_i);
		if (s == 0) breq <= r;
		else if (s == 1) wreq <= r;
		else preq <= r;
		psel <= sel;
		#1;
		f = (s == 0) ? bfwd : (s == 1) ? wfwd : pfwd;
		check_bit(f.valid, !rf);
		if (s == 2) check(32'(psel_fwd), rf ? 32'h0000_0000 : 32'(sel));
		@(posedge ref_clk_i);
		breq <= '0;
		wreq <= '0;
		preq <= '0;
		psel <= '0;
		#1;
		q = (s == 0) ? brsp : (s == 1) ? wrsp : prsp;
		check_bit(q.valid, 1'b1);
		check_bit(q.error, rf & e);
		check(q.rdata, rf ? REFUSE_RDATA : a ^ 32'h5A5A_0000);
		check_bit(evt.pulse, rf);
		if (rf) begin
			check(32'({evt.src, evt.write, evt.nonsec}), 32'({s[1:0], w, n}));
			check(evt.addr, a);
			@(posedge ref_clk_i);
			#1;
			check_bit(evt.pulse, 1'b0);
		end
	endtask : access

	task automatic t_reset;
		reg_read(OFF_CTRL, 32'h0000_0000);
		reg_read(OFF_WMARK, 32'h0000_0000);
		reg_read(OFF_PNS, 32'h0000_0000);
		reg_read(OFF_PPRIV, 32'h0000_0000);
		reg_read(OFF_BLK0, 32'h0000_0000);
		reg_read(8'h40, 32'h0000_0000);
		access(0, 0, 1, 1, 32'h0000_0100, 0, 1, 0);
	endtask : t_reset

	task automatic t_block;
		reg_write(OFF_BLK0, 32'h0000_0002, 1'b1);
		reg_read(OFF_BLK0, 32'h0000_0000);
		reg_write(OFF_BLK0, 32'h0000_0002, 1'b0);
		reg_read(OFF_BLK0, 32'h0000_0002);
		access(0, 0, 1, 0, 32'h0000_0100, 0, 0, 0);
		access(0, 0, 1, 0, 32'h0000_01FC, 0, 0, 0);
		access(0, 0, 1, 0, 32'h0000_0200, 0, 1, 0);
		access(0, 0, 0, 0, 32'h0000_0180, 0, 1, 0);
		access(0, 1, 0, 0, 32'h0000_0180, 0, 0, 0);
		reg_write(OFF_CTRL, 32'h0000_0003, 1'b0);
		access(0, 1, 0, 0, 32'h0000_0180, 0, 1, 1);
		access(0, 1, 1, 0, 32'h0000_0040, 0, 1, 1);
		reg_read(OFF_EVADDR, 32'h0000_0040);
		reg_read(OFF_EVINFO, 32'h0000_0003);
		access(0, 0, 0, 0, 32'h0000_0040, 0, 0, 0);
	endtask : t_block

	task automatic t_wmark;
		access(1, 0, 1, 0, 32'h0000_0000, 0, 1, 1);
		reg_write(OFF_WMARK, 32'h0000_0800, 1'b0);
		reg_write(OFF_CTRL, 32'h0000_0004, 1'b0);
		access(1, 0, 1, 0, 32'h0000_07FC, 0, 0, 0);
		access(1, 1, 1, 0, 32'h0000_0800, 0, 1, 0);
		access(1, 0, 0, 0, 32'h0000_07FC, 0, 1, 0);
		access(1, 0, 0, 0, 32'h0000_0800, 0, 0, 0);
	endtask : t_wmark

	task automatic t_periph;
		access(2, 0, 1, 1, 32'h0000_0010, 16'h0004, 1, 0);
		reg_write(OFF_PNS, 32'h0000_0004, 1'b0);
		access(2, 0, 1, 1, 32'h0000_0010, 16'h0002, 1, 0);
		access(2, 1, 1, 0, 32'h0000_0010, 16'h0004, 0, 0);
		reg_write(OFF_PPRIV, 32'h0000_0004, 1'b0);
		access(2, 0, 1, 0, 32'h0000_0010, 16'h0004, 1, 0);
		access(2, 0, 1, 1, 32'h0000_0010, 16'h0004, 0, 0);
		access(2, 0, 0, 1, 32'h0000_0010, 16'h0004, 0, 0);
		reg_write(OFF_CTRL, 32'h0000_0009, 1'b0);
		access(2, 0, 0, 1, 32'h0000_0010, 16'h0004, 1, 1);
	endtask : t_periph

	task automatic t_rereset;
		@(posedge ref_clk_i);
		rst_b_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		reg_read(OFF_EVADDR, 32'h0000_0000);
		t_reset();
	endtask : t_rereset

	initial begin
		ref_clk_i = 1'b0;
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end

	// Hang guard
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			test_done();
		end
	end

	initial begin
		num_errors = 0;
		checks_done = 0;
		cycles = 0;
		rst_b_i = 1'b0;
		ra = '0;
		rwd = '0;
		rwr = 1'b0;
		rrd_s = 1'b0;
		rns = 1'b0;
		breq = '0;
		wreq = '0;
		preq = '0;
		psel = '0;
		repeat (6) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		t_reset();
		t_block();
		t_wmark();
		t_periph();
		t_rereset();
		test_done();
	end
endmodule : sgc_gate_test
